// [bench/cdic_core_model.sv]
// partner model: core sequencer and interrupt logic feeding the control block
`timescale 1ns/1ps
module cdic_core_model (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic [5:0]  req,
    output cdic_pkg::cdic_core_s core
);
    import cdic_pkg::*;
    // ------------------------------------------------------------
    // peripheral cycle source
    // ------------------------------------------------------------
    // one peripheral cycle per clock keeps ratio windows short
    logic pcyc_q;
    always_ff @(posedge core_clk) begin
        pcyc_q <= !srst;
    end
    // req holds sleep, isr entry, return, irq level, watchdog, debug level
    assign core = cdic_core_s'({req, pcyc_q});
endmodule

// [bench/tb_cpu_doze_idle_control.sv]
// testbench: register, doze ratio, interrupt and power mode checks
`timescale 1ns/1ps
module tb_cpu_doze_idle_control;
    import cdic_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        core_clk;
    logic        srst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [3:0]  pstrb;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        perr;
    logic [5:0]  req;
    cdic_core_s  core;
    logic        cpu_cycle_en;
    logic        cpu_clk_en;
    logic        periph_clk_en;
    logic        lps;
    logic        device_sleep;
    logic        wdt_reset_block;
    int          n_fail;
    int          n_tests;
    cdic_top uut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core(core), .cpu_cycle_en(cpu_cycle_en), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .regulator_low_power_sleep_select(lps), .device_sleep(device_sleep), .wdt_reset_block(wdt_reset_block));
    cdic_core_model partner (.core_clk(core_clk), .srst(srst), .req(req), .core(core));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        r = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16) chk(0, 1, "no ready");
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string m);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r, e, m);
    endtask
    task automatic pulse(input int i);
        @(posedge core_clk);
        req[i] <= 1'b1;
        @(posedge core_clk);
        req[i] <= 1'b0;
    endtask
    task automatic grants(input int n, input int e, input string m);
        int c;
        c = 0;
        repeat (4) @(posedge core_clk);
        repeat (n) begin
            @(posedge core_clk);
            if (cpu_cycle_en === 1'b1) c++;
        end
        chk(c, e, m);
    endtask
    task automatic settle();
        repeat (3) @(posedge core_clk);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd(ADDR_VREG, 32'h1, "vreg reset");
        rd(ADDR_DOZE, 32'h0, "doze reset");
        wr(ADDR_VREG, 32'hFF);
        rd(ADDR_VREG, 32'h3, "vreg unimpl");
        chk(lps, 1, "lps set");
        wr(ADDR_VREG, 32'h1);
        rd(ADDR_VREG, 32'h1, "vreg bit0");
        chk(lps, 0, "lps clr");
        wr(ADDR_DOZE, 32'hFF);
        rd(ADDR_DOZE, 32'hF7, "doze unimpl");
        rd(12'h00C, 32'h0, "unmapped");
        chk(perr, 1, "unmapped err");
        // a write with its low byte strobe off must leave the register alone
        pstrb <= 4'h0;
        wr(ADDR_VREG, 32'h3);
        pstrb <= 4'hF;
        rd(ADDR_VREG, 32'h1, "strobe off");
        $display("test regs done");
    endtask
    task automatic t_ratio();
        // window of 512 is a multiple of every ratio, so phase cannot skew it
        for (int k = 0; k < 8; k++) begin
            wr(ADDR_DOZE, 32'h40 | k);
            grants(512, 512 >> (k + 1), "ratio");
        end
        wr(ADDR_DOZE, 32'h0);
        grants(64, 64, "full speed");
        // re-enable at 1:256 restarts the count, so no grant in the first 200 cycles
        wr(ADDR_DOZE, 32'h47);
        grants(200, 0, "ratio restart");
        $display("test ratio done");
    endtask
    task automatic t_irq();
        wr(ADDR_DOZE, 32'h60);
        pulse(4);
        rd(ADDR_DOZE, 32'h20, "roi clears");
        wr(ADDR_DOZE, 32'h40);
        pulse(4);
        rd(ADDR_DOZE, 32'h40, "no roi");
        wr(ADDR_DOZE, 32'h10);
        pulse(3);
        rd(ADDR_DOZE, 32'h50, "doe sets");
        wr(ADDR_DOZE, 32'h0);
        pulse(3);
        rd(ADDR_DOZE, 32'h0, "no doe");
        wr(ADDR_DOZE, 32'h47);
        req[0] <= 1'b1;
        grants(64, 64, "debug speed");
        req[0] <= 1'b0;
        rd(ADDR_DOZE, 32'h47, "debug keeps");
        $display("test irq done");
    endtask
    task automatic t_idle();
        wr(ADDR_DOZE, 32'hE0);
        pulse(5);
        settle();
        chk(cpu_clk_en, 0, "idle cpu");
        chk(periph_clk_en, 1, "idle periph");
        chk(wdt_reset_block, 1, "idle wdt block");
        chk(cpu_cycle_en, 0, "idle no cycles");
        rd(ADDR_STATUS, 32'h1, "status idle");
        pulse(1);
        settle();
        chk(cpu_clk_en, 1, "wdt wake");
        chk(wdt_reset_block, 0, "wake wdt block");
        rd(ADDR_DOZE, 32'hE0, "wdt no roi");
        pulse(5);
        settle();
        chk(cpu_clk_en, 0, "idle again");
        req[2] <= 1'b1;
        settle();
        chk(cpu_clk_en, 1, "irq wake");
        req[2] <= 1'b0;
        rd(ADDR_DOZE, 32'hE0, "idle kept");
        $display("test idle done");
    endtask
    task automatic t_sleep();
        wr(ADDR_DOZE, 32'h0);
        wr(ADDR_VREG, 32'h3);
        pulse(5);
        settle();
        chk(device_sleep, 1, "full sleep");
        chk(periph_clk_en, 0, "sleep periph");
        chk(cpu_clk_en, 0, "sleep cpu");
        chk(lps, 1, "sleep lps");
        rd(ADDR_STATUS, 32'hA, "status sleep");
        pulse(1);
        settle();
        chk(device_sleep, 0, "sleep wake");
        $display("test sleep done");
    endtask
    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        // ratio sweep needs about 4400 cycles, the rest far less
        repeat (20000) @(posedge core_clk);
        n_fail++;
        summarize();
    end
    initial begin
        n_fail = 0;
        n_tests = 0;
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        req = 6'h00;
        perr = 1'b0;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        t_regs();
        t_ratio();
        t_irq();
        t_idle();
        t_sleep();
        summarize();
    end
endmodule

// [src/cdic_pkg.sv]
// package: register map, field layout and types of the doze and idle control block
package cdic_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_VREG   = 12'h000;
    localparam logic [11:0] ADDR_DOZE   = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int VREG_RSVD_BIT  = 0;
    localparam int VREG_LPS_BIT   = 1;
    localparam int DOZE_RATIO_LSB = 0;
    localparam int DOZE_ROR_BIT   = 4;
    localparam int DOZE_ROI_BIT   = 5;
    localparam int DOZE_ACT_BIT   = 6;
    localparam int DOZE_IDLE_BIT  = 7;
    localparam int ST_IDLE_BIT    = 0;
    localparam int ST_SLEEP_BIT   = 1;
    localparam int ST_RUN_BIT     = 2;
    localparam int ST_LPS_BIT     = 3;
    // ------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] VREG_RESET = 8'h01;
    localparam logic [7:0] VREG_MASK  = 8'h03;
    localparam logic [7:0] DOZE_RESET = 8'h00;
    localparam logic [7:0] DOZE_MASK  = 8'hF7;
    localparam logic [2:0] RATIO_RESET = 3'h0;
    localparam logic [7:0] CNT_ONE    = 8'h01;
    localparam logic [7:0] CNT_ZERO   = 8'h00;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CDIC_RUN   = 3'b001,
        CDIC_IDLE  = 3'b010,
        CDIC_SLEEP = 3'b100
    } cdic_mode_e;

    typedef struct packed {
        logic sleep_instr;
        logic isr_entry;
        logic return_from_interrupt_instruction;
        logic irq_pending;
        logic wdt_timeout;
        logic in_circuit_debug_mode;
        logic periph_cycle;
    } cdic_core_s;

    function automatic logic [7:0] cdic_ratio_mask(input logic [2:0] code);
        // 2^(code+1)-1, count wraps at the chosen ratio
        cdic_ratio_mask = 8'((9'h002 << code) - 9'h001);
    endfunction
endpackage

// [src/cdic_throttle.sv]
// module: doze ratio counter that grants cpu instruction cycles
`timescale 1ns/1ps
module cdic_throttle (
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       periph_cycle,
    input  wire logic       throttle_on,
    input  wire logic [2:0] ratio,
    output logic            grant
);
    import cdic_pkg::*;

    logic [7:0] cnt_q;
    logic       on_q;

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    // restarts whenever throttling is switched back on
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cnt_q <= CNT_ZERO;
            on_q  <= 1'b0;
        end else begin
            on_q <= throttle_on;
            if (throttle_on && !on_q) begin
                cnt_q <= CNT_ZERO;
            end else if (periph_cycle) begin
                if ((cnt_q & cdic_ratio_mask(ratio)) == cdic_ratio_mask(ratio)) begin
                    cnt_q <= CNT_ZERO;
                end else begin
                    cnt_q <= cnt_q + CNT_ONE;
                end
            end
        end
    end

    // one grant per wrap when throttled, every cycle otherwise
    always_comb begin
        if (!throttle_on) begin
            grant = periph_cycle;
        end else begin
            grant = periph_cycle && ((cnt_q & cdic_ratio_mask(ratio)) == cdic_ratio_mask(ratio));
        end
    end
endmodule

// [src/cdic_top.sv]
// module: cpu doze, idle and sleep regulator control with apb register slave
// ------------------------------------------------------------
// Notes on behaviour
// - regulator bit one selects low-power sleep
// - regulator bit zero reads one, keep set
// - unimplemented bits always read zero
// - idle select: sleep stops cpu only
// - idle clear: sleep enters full sleep
// - doze active throttles cpu, else full
// - recover bit clears doze on isr entry
// - return bit sets doze on interrupt return
// - ratio code n gives one to 2^(n+1)
// - hardware changes doze bit only when enabled
// - debug runs full speed, doze bit kept
// - enabled interrupt ends idle, select unchanged
// - watchdog wakes from idle, no recover
// ------------------------------------------------------------
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
module cdic_top (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire cdic_pkg::cdic_core_s core,
    output logic             cpu_cycle_en,
    output logic             cpu_clk_en,
    output logic             periph_clk_en,
    output logic             regulator_low_power_sleep_select,
    output logic             device_sleep,
    output logic             wdt_reset_block
);
    import cdic_pkg::*;

    logic [7:0] vreg_q;
    logic [7:0] doze_q;
    cdic_mode_e mode_q;
    logic       grant;
    logic       wr_acc;
    logic       rd_acc;
    logic       hit;
    logic       wr_doze;
    logic       hw_set;
    logic       hw_clr;
    logic       throttle_on;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign hit     = (paddr == ADDR_VREG) || (paddr == ADDR_DOZE) || (paddr == ADDR_STATUS);
    assign wr_acc  = psel && penable && pwrite && pready;
    assign rd_acc  = psel && !penable && !pwrite;
    assign wr_doze = wr_acc && (paddr == ADDR_DOZE) && pstrb[0];

    // ------------------------------------------------------------
    // regulator control
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            vreg_q <= VREG_RESET;
        end else if (wr_acc && (paddr == ADDR_VREG) && pstrb[0]) begin
            // reserved bit is forced set, a careless write cannot clear it
            vreg_q <= (pwdata[7:0] & VREG_MASK) | VREG_RESET;
        end
    end

    // ------------------------------------------------------------
    // doze and idle control
    // ------------------------------------------------------------
    // interrupt entry/return only touch the doze bit when enabled
    assign hw_clr = core.isr_entry && doze_q[DOZE_ROI_BIT];
    assign hw_set = core.return_from_interrupt_instruction && doze_q[DOZE_ROR_BIT];

    always_ff @(posedge core_clk) begin
        if (srst) begin
            doze_q <= DOZE_RESET;
        end else begin
            if (wr_doze) begin
                doze_q <= pwdata[7:0] & DOZE_MASK;
            end
            // hardware events win over a software write in the same cycle
            if (hw_set) begin
                doze_q[DOZE_ACT_BIT] <= 1'b1;
            end else if (hw_clr) begin
                doze_q[DOZE_ACT_BIT] <= 1'b0;
            end
        end
    end

    // debug overrides throttling without touching the stored bit
    assign throttle_on = doze_q[DOZE_ACT_BIT] && !core.in_circuit_debug_mode;

    cdic_throttle u_throttle (
        .core_clk     (core_clk),
        .srst         (srst),
        .periph_cycle (core.periph_cycle),
        .throttle_on  (throttle_on),
        .ratio        (doze_q[DOZE_RATIO_LSB +: 3]),
        .grant        (grant)
    );

    // ------------------------------------------------------------
    // power mode machine
    // ------------------------------------------------------------
    // the idle select bit is never written here, so a later sleep re-enters idle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mode_q <= CDIC_RUN;
        end else begin
            unique case (mode_q)
                CDIC_RUN: begin
                    if (core.sleep_instr && !core.irq_pending) begin
                        mode_q <= doze_q[DOZE_IDLE_BIT] ? CDIC_IDLE : CDIC_SLEEP;
                    end
                end
                CDIC_IDLE: begin
                    if (core.irq_pending || core.wdt_timeout) begin
                        mode_q <= CDIC_RUN;
                    end
                end
                CDIC_SLEEP: begin
                    if (core.irq_pending || core.wdt_timeout) begin
                        mode_q <= CDIC_RUN;
                    end
                end
                default: begin
                    mode_q <= CDIC_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // core-facing outputs, registered
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cpu_cycle_en                     <= 1'b0;
            cpu_clk_en                       <= 1'b1;
            periph_clk_en                    <= 1'b1;
            regulator_low_power_sleep_select <= 1'b0;
            device_sleep                     <= 1'b0;
            wdt_reset_block                  <= 1'b0;
        end else begin
            // one cycle late against the peripheral cycle; cheap, and keeps outputs flopped
            cpu_cycle_en                     <= grant && (mode_q == CDIC_RUN);
            cpu_clk_en                       <= (mode_q == CDIC_RUN);
            periph_clk_en                    <= (mode_q != CDIC_SLEEP);
            regulator_low_power_sleep_select <= vreg_q[VREG_LPS_BIT];
            device_sleep                     <= (mode_q == CDIC_SLEEP);
            wdt_reset_block                  <= (mode_q == CDIC_IDLE);
        end
    end

    // ------------------------------------------------------------
    // apb read and response
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            if (rd_acc) begin
                unique case (paddr)
                    ADDR_VREG:   prdata <= {24'h00_0000, vreg_q & VREG_MASK};
                    ADDR_DOZE:   prdata <= {24'h00_0000, doze_q & DOZE_MASK};
                    ADDR_STATUS: prdata <= {28'h000_0000, vreg_q[VREG_LPS_BIT],
                                            mode_q == CDIC_RUN, mode_q == CDIC_SLEEP, mode_q == CDIC_IDLE};
                    default:     prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_rsvd_set;
        @(posedge core_clk) disable iff (srst) 1'b1 |-> vreg_q[VREG_RSVD_BIT];
    endproperty
    a_rsvd_set: assert property (p_rsvd_set) else $error("reserved bit cleared");

    property p_lps_out;
        @(posedge core_clk) disable iff (srst) 1'b1 |=> regulator_low_power_sleep_select == $past(vreg_q[VREG_LPS_BIT]);
    endproperty
    a_lps_out: assert property (p_lps_out) else $error("regulator select mismatch");

    property p_unimpl_zero;
        @(posedge core_clk) disable iff (srst) (vreg_q[7:2] == 6'h00) && (doze_q[3] == 1'b0);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

    property p_idle_entry;
        @(posedge core_clk) disable iff (srst)
            (mode_q == CDIC_RUN && core.sleep_instr && !core.irq_pending && doze_q[DOZE_IDLE_BIT])
            |=> mode_q == CDIC_IDLE ##1 (!cpu_clk_en && periph_clk_en);
    endproperty
    a_idle_entry: assert property (p_idle_entry) else $error("idle entry wrong");

    property p_sleep_entry;
        @(posedge core_clk) disable iff (srst)
            (mode_q == CDIC_RUN && core.sleep_instr && !core.irq_pending && !doze_q[DOZE_IDLE_BIT])
            |=> ##1 device_sleep && !periph_clk_en;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");

    property p_full_speed;
        @(posedge core_clk) disable iff (srst)
            (!throttle_on && mode_q == CDIC_RUN && core.periph_cycle) |=> cpu_cycle_en;
    endproperty
    a_full_speed: assert property (p_full_speed) else $error("full speed cycle lost");

    property p_roi;
        @(posedge core_clk) disable iff (srst)
            (core.isr_entry && doze_q[DOZE_ROI_BIT] && !hw_set) |=> !doze_q[DOZE_ACT_BIT];
    endproperty
    a_roi: assert property (p_roi) else $error("recover did not clear doze");

    property p_ror;
        @(posedge core_clk) disable iff (srst) hw_set |=> doze_q[DOZE_ACT_BIT];
    endproperty
    a_ror: assert property (p_ror) else $error("return did not set doze");

    property p_hw_only_enabled;
        @(posedge core_clk) disable iff (srst)
            (!wr_doze && !hw_set && !hw_clr) |=> $stable(doze_q[DOZE_ACT_BIT]);
    endproperty
    a_hw_only_enabled: assert property (p_hw_only_enabled) else $error("doze bit changed spuriously");

    property p_idle_wake;
        @(posedge core_clk) disable iff (srst)
            (mode_q == CDIC_IDLE && (core.irq_pending || core.wdt_timeout)) |=> mode_q == CDIC_RUN && $stable(doze_q[DOZE_IDLE_BIT]);
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle wake failed");

    property p_ratio_grant;
        @(posedge core_clk) disable iff (srst)
            (throttle_on && $stable(doze_q) && doze_q[2:0] == 3'h0 && core.periph_cycle && grant)
            |-> !$past(grant);
    endproperty
    a_ratio_grant: assert property (p_ratio_grant) else $error("doze ratio violated");
endmodule
